// ### src/slk_regs.svh
`ifndef SLK_REGS_SVH
`define SLK_REGS_SVH

// device register offsets
`define SLK_OFS_CTRL1     10'h201
`define SLK_OFS_CTRL2     10'h202
`define SLK_OFS_DID       10'h203
`define SLK_OFS_CTRL3     10'h204
`define SLK_OFS_STAT      10'h205

// device reset values
`define SLK_RST_CTRL1     8'h0f
`define SLK_RST_CTRL2     8'h00
`define SLK_RST_DID       8'h00
`define SLK_RST_CTRL3     8'h00

// field positions
`define SLK_C1_SCR        7
`define SLK_C1_K_HI       6
`define SLK_C1_K_LO       2
`define SLK_C1_DDR        1
`define SLK_C1_EN         0
`define SLK_C2_PLL        7
`define SLK_C2_SYNCSEL    6
`define SLK_C2_TEST_HI    3
`define SLK_C3_FE_HI      1
`define SLK_ST_LINK_UP    6
`define SLK_ST_SYNC       5

// control and data characters
`define SLK_K28_0         8'h1c
`define SLK_K28_1         8'h3c
`define SLK_K28_3         8'h7c
`define SLK_K28_4         8'h9c
`define SLK_K28_5         8'hbc
`define SLK_K28_7         8'hfc
`define SLK_D21_5         8'hb5

// bit rate in quarters of the sample clock
`define SLK_RATE_SDR      4'h4
`define SLK_RATE_DDR      4'h8
`define SLK_RATE_SDR_P54  4'h5
`define SLK_RATE_DDR_P54  4'ha

// alignment sequence and generator seeds
`define SLK_ILA_LAST      2'h3
`define SLK_ILA_DID_MF    2'h1
`define SLK_PRBS_SEED     23'h7fffff
`define SLK_SCR_SEED      15'h7fff

// controller register offsets
`define SLK_HR_ADDR       3'h0
`define SLK_HR_WDATA      3'h1
`define SLK_HR_CMD        3'h2
`define SLK_HR_STAT       3'h3

`endif

// ### src/slk_pkg.sv
package slk_pkg;

	// transmitter link states
	typedef enum logic [1:0] {
		slk_off  = 2'b00,
		slk_cgs  = 2'b01,
		slk_ila  = 2'b10,
		slk_data = 2'b11
	} slk_link_t;

	// link test pattern codes
	typedef enum logic [3:0] {
		slk_tp_normal    = 4'h0,
		slk_tp_prbs7     = 4'h1,
		slk_tp_prbs15    = 4'h2,
		slk_tp_prbs23    = 4'h3,
		slk_tp_ramp      = 4'h4,
		slk_tp_transport = 4'h5,
		slk_tp_d21       = 4'h6,
		slk_tp_k28       = 4'h7,
		slk_tp_rep_ila   = 4'h8,
		slk_tp_rpat      = 4'h9,
		slk_tp_hold_low  = 4'ha,
		slk_tp_hold_high = 4'hb
	} slk_test_t;

	// controller sequencer states
	typedef enum logic [1:0] {
		slk_h_idle = 2'b00,
		slk_h_pre  = 2'b01,
		slk_h_acc  = 2'b10,
		slk_h_cap  = 2'b11
	} slk_hst_t;

endpackage : slk_pkg

// ### src/slk_if.sv
`timescale 1ns/1ps
`default_nettype none

// register port between the controller and the transmitter
interface slk_if;
	logic [9:0] addr;
	logic [7:0] wdata;
	logic       wr;
	logic       rd;
	logic [7:0] rdata;

	modport dev  (input addr, input wdata, input wr, input rd, output rdata);
	modport host (output addr, output wdata, output wr, output rd, input rdata);
endinterface : slk_if

`default_nettype wire

// ### src/slk_dev.sv
`timescale 1ns/1ps
`default_nettype none
`include "slk_regs.svh"

module slk_fifo #(
	parameter int W = 8,
	parameter int D = 8
) (
	// clock and reset
	input  wire logic         clk,
	input  wire logic         rst,
	// fill side
	input  wire logic         in_valid,
	input  wire logic [W-1:0] in_data,
	output logic              in_ready,
	// drain side
	output logic              out_valid,
	output logic [W-1:0]      out_data,
	input  wire logic         out_ready
);
	localparam int AW = (D > 1) ? $clog2(D) : 1;
	localparam int CW = $clog2(D + 1);

	typedef struct packed {
		logic [D-1:0][W-1:0] mem;
		logic [AW-1:0]       wp;
		logic [AW-1:0]       rp;
		logic [CW-1:0]       cnt;
		logic                rdy;
	} slk_fifo_st_t;

	slk_fifo_st_t q, d;
	logic         push;
	logic         pop;

	// ready is registered so the fill side never sees a combinational path
	always_comb begin
		d = q;
		push = in_valid && q.rdy;
		pop = out_ready && (q.cnt != '0);
		if (push) begin
			d.mem[q.wp] = in_data;
			d.wp = (q.wp == AW'(D - 1)) ? '0 : q.wp + 1'b1;
		end
		if (pop) begin
			d.rp = (q.rp == AW'(D - 1)) ? '0 : q.rp + 1'b1;
		end
		d.cnt = q.cnt + CW'(push) - CW'(pop);
		d.rdy = (d.cnt != CW'(D));
		if (rst) begin
			d = '0;
			d.rdy = 1'b1;
		end
	end

	always_ff @(posedge clk) begin
		q <= d;
	end

	assign in_ready  = q.rdy;
	assign out_valid = (q.cnt != '0);
	assign out_data  = q.mem[q.rp];
endmodule : slk_fifo

// Summary of operation
// - scramble_on bit enables lane scrambler, reset off
// - bits 6..2 hold frames per multiframe minus one
// - software keeps frame count legal for mode
// - double-rate bit doubles serial bit rate
// - five-quarter pll scales rate 1.25 or 2.5
// - enable low holds link reset, serializers down
// - enable low gates transmitter clocks off
// - software clears enable before changing primary control
// - other config changed only while enable low
// - sync_input_select picks single-ended or differential sync
// - test field picks normal data or patterns
// - codes 10 and 11 hold outputs low/high
// - identifier sent in second alignment multiframe
// - frame end code picks K28.7, K28.1, K28.5
// - frame end character inserted by replacement
// - use code 0 with standard receivers
// - link-up status only in data state
module slk_dev #(
	parameter int FIFO_DEPTH = 8
) (
	// clock and reset
	input  wire logic       clk,
	input  wire logic       rst,
	// register port
	slk_if.dev              bus,
	// sample stream in
	input  wire logic       s_valid,
	input  wire logic [7:0] s_data,
	output logic            s_ready,
	// sync request pins, active low
	input  wire logic       sync_single_ended_input,
	input  wire logic       sync_differential_input,
	// lane and serializer control
	output logic [7:0]      lane_char,
	output logic            lane_is_k,
	output logic            lane_hold_low,
	output logic            lane_hold_high,
	output logic            ser_power_down,
	output logic            tx_clk_enable,
	output logic [3:0]      bit_rate_quarters
);
	import slk_pkg::*;

	typedef struct packed {
		logic [7:0]  c1, c2, did, c3;
		logic [7:0]  a1, a2, ad, a3;
		logic [7:0]  rdata;
		logic        sse1, sse2, sdf1, sdf2;
		slk_link_t   st;
		logic [4:0]  fr;
		logic [1:0]  mf;
		logic [14:0] scramble_on;
		logic [22:0] prbs;
		logic [7:0]  ramp;
		logic [7:0]  last;
		logic [7:0]  ch;
		logic        k, lo, hi, pd, cke;
		logic [3:0]  rate;
	} slk_dev_st_t;

	slk_dev_st_t q, d;
	slk_test_t   tp;
	logic [4:0]  kmax;
	logic        last_fr;
	logic        sync_lvl;
	logic [7:0]  fe;
	logic [7:0]  bv;
	logic        pop;
	logic        f_valid;
	logic [7:0]  f_data;
	logic [30:0] pr;
	logic [22:0] sc;

	// byte-wide prbs generator, eight serial steps per character
	function automatic logic [30:0] slk_prbs_step(input logic [22:0] s_in, input slk_test_t m);
		logic [22:0] s;
		logic [7:0]  o;
		logic        fb;
		s = s_in;
		o = '0;
		fb = 1'b0;
		for (int i = 0; i < 8; i++) begin
			if (m == slk_tp_prbs7)
				fb = s[6] ^ s[5];
			else if (m == slk_tp_prbs15)
				fb = s[14] ^ s[13];
			else
				fb = s[22] ^ s[17];
			s = {s[21:0], fb};
			o = {o[6:0], fb};
		end
		return {o, s};
	endfunction : slk_prbs_step

	// self-synchronous scrambler 1 + x^14 + x^15, msb first
	function automatic logic [22:0] slk_scramble(input logic [7:0] din, input logic [14:0] s_in);
		logic [14:0] s;
		logic [7:0]  o;
		s = s_in;
		o = '0;
		for (int i = 7; i >= 0; i--) begin
			o[i] = din[i] ^ s[14] ^ s[13];
			s = {s[13:0], o[i]};
		end
		return {o, s};
	endfunction : slk_scramble

	slk_fifo #(.W(8), .D(FIFO_DEPTH)) slk_fifo_i (
		.clk       (clk),
		.rst       (rst),
		.in_valid  (s_valid),
		.in_data   (s_data),
		.in_ready  (s_ready),
		.out_valid (f_valid),
		.out_data  (f_data),
		.out_ready (pop)
	);

	// whole next state; the link runs from the active copy, never the live registers
	always_comb begin
		d = q;
		tp = slk_test_t'(q.a2[`SLK_C2_TEST_HI:0]);
		kmax = q.a1[`SLK_C1_K_HI:`SLK_C1_K_LO];
		last_fr = (q.fr == kmax);
		sync_lvl = q.a2[`SLK_C2_SYNCSEL] ? q.sdf2 : q.sse2;
		unique case (q.a3[`SLK_C3_FE_HI:0])
			2'h1: fe = `SLK_K28_1;
			2'h2: fe = `SLK_K28_5;
			default: fe = `SLK_K28_7;
		endcase
		pop = 1'b0;
		bv = '0;
		pr = '0;
		sc = '0;
		// two-stage synchronisers on the sync pins
		d.sse1 = sync_single_ended_input;
		d.sse2 = q.sse1;
		d.sdf1 = sync_differential_input;
		d.sdf2 = q.sdf1;
		// register writes and one-cycle read answer
		d.rdata = '0;
		if (bus.wr) begin
			unique case (bus.addr)
				`SLK_OFS_CTRL1: d.c1 = bus.wdata;
				`SLK_OFS_CTRL2: d.c2 = bus.wdata;
				`SLK_OFS_DID:   d.did = bus.wdata;
				`SLK_OFS_CTRL3: d.c3 = bus.wdata;
				default: ;
			endcase
		end
		if (bus.rd) begin
			unique case (bus.addr)
				`SLK_OFS_CTRL1: d.rdata = q.c1;
				`SLK_OFS_CTRL2: d.rdata = q.c2;
				`SLK_OFS_DID:   d.rdata = q.did;
				`SLK_OFS_CTRL3: d.rdata = q.c3;
				`SLK_OFS_STAT: begin
					d.rdata[`SLK_ST_LINK_UP] = (q.st == slk_data);
					d.rdata[`SLK_ST_SYNC] = sync_lvl;
				end
				default: d.rdata = '0;
			endcase
		end
		// active copy taken only on the enable rise
		if (!q.c1[`SLK_C1_EN]) begin
			d.a1[`SLK_C1_EN] = 1'b0;
		end else if (!q.a1[`SLK_C1_EN]) begin
			d.a1 = q.c1;
			d.a2 = q.c2;
			d.ad = q.did;
			d.a3 = q.c3;
		end
		// link sequencer, one character per clock
		d.ch = '0;
		d.k = 1'b0;
		unique case (q.st)
			slk_off: begin
				d.fr = '0;
				d.mf = '0;
				d.scramble_on = `SLK_SCR_SEED;
				d.prbs = `SLK_PRBS_SEED;
				d.ramp = '0;
				d.last = '0;
				if (q.a1[`SLK_C1_EN])
					d.st = slk_cgs;
			end
			slk_cgs: begin
				d.ch = `SLK_K28_5;
				d.k = 1'b1;
				if (sync_lvl) begin
					d.st = slk_ila;
					d.fr = '0;
					d.mf = '0;
				end
			end
			slk_ila: begin
				d.fr = last_fr ? '0 : q.fr + 1'b1;
				d.k = 1'b1;
				if (q.fr == '0)
					d.ch = `SLK_K28_0;
				else if (last_fr)
					d.ch = `SLK_K28_3;
				else if (q.mf == `SLK_ILA_DID_MF && q.fr == 5'h01)
					d.ch = `SLK_K28_4;
				else if (q.mf == `SLK_ILA_DID_MF && q.fr == 5'h02) begin
					d.ch = q.ad;
					d.k = 1'b0;
				end else begin
					d.ch = {3'h0, q.fr};
					d.k = 1'b0;
				end
				if (last_fr) begin
					d.mf = q.mf + 1'b1;
					if (q.mf == `SLK_ILA_LAST && tp != slk_tp_rep_ila)
						d.st = slk_data;
				end
			end
			slk_data: begin
				d.fr = last_fr ? '0 : q.fr + 1'b1;
				unique case (tp)
					slk_tp_prbs7, slk_tp_prbs15, slk_tp_prbs23: begin
						pr = slk_prbs_step(q.prbs, tp);
						d.ch = pr[30:23];
						d.prbs = pr[22:0];
					end
					slk_tp_ramp: begin
						d.ch = q.ramp;
						d.ramp = q.ramp + 1'b1;
					end
					slk_tp_transport: d.ch = {3'h0, q.fr};
					slk_tp_d21: d.ch = `SLK_D21_5;
					slk_tp_k28: begin
						d.ch = `SLK_K28_5;
						d.k = 1'b1;
					end
					slk_tp_rpat: begin
						sc = slk_scramble(q.ramp, q.scramble_on);
						d.ch = sc[22:15];
						d.scramble_on = sc[14:0];
						d.ramp = q.ramp + 1'b1;
					end
					default: begin
						// an empty fifo sends zero bytes rather than stalling the lane
						pop = f_valid;
						bv = f_valid ? f_data : 8'h00;
						if (q.a1[`SLK_C1_SCR]) begin
							sc = slk_scramble(bv, q.scramble_on);
							d.scramble_on = sc[14:0];
							d.ch = sc[22:15];
							d.k = last_fr ? (sc[22:15] == `SLK_K28_3) : (sc[22:15] == fe);
						end else if (bv == q.last) begin
							d.ch = last_fr ? `SLK_K28_3 : fe;
							d.k = 1'b1;
						end else begin
							d.ch = bv;
						end
						d.last = bv;
					end
				endcase
			end
		endcase
		// losing sync mid-link falls back to code group sync
		if ((q.st == slk_ila || q.st == slk_data) && !sync_lvl)
			d.st = slk_cgs;
		if (!q.a1[`SLK_C1_EN])
			d.st = slk_off;
		// serializer control and fixed output levels
		d.pd = !q.a1[`SLK_C1_EN];
		d.cke = q.a1[`SLK_C1_EN];
		d.lo = q.a1[`SLK_C1_EN] && (tp == slk_tp_hold_low);
		d.hi = q.a1[`SLK_C1_EN] && (tp == slk_tp_hold_high);
		if (d.lo || d.hi) begin
			d.ch = d.hi ? 8'hff : 8'h00;
			d.k = 1'b0;
		end
		unique case ({q.a2[`SLK_C2_PLL], q.a1[`SLK_C1_DDR]})
			2'b00: d.rate = `SLK_RATE_SDR;
			2'b01: d.rate = `SLK_RATE_DDR;
			2'b10: d.rate = `SLK_RATE_SDR_P54;
			2'b11: d.rate = `SLK_RATE_DDR_P54;
		endcase
		if (rst) begin
			d = '0;
			d.c1 = `SLK_RST_CTRL1;
			d.c2 = `SLK_RST_CTRL2;
			d.did = `SLK_RST_DID;
			d.c3 = `SLK_RST_CTRL3;
			d.a1 = `SLK_RST_CTRL1;
			d.a2 = `SLK_RST_CTRL2;
			d.ad = `SLK_RST_DID;
			d.a3 = `SLK_RST_CTRL3;
			d.st = slk_off;
			d.pd = 1'b1;
			d.rate = `SLK_RATE_DDR;
		end
	end

	always_ff @(posedge clk) begin
		q <= d;
	end

	assign bus.rdata         = q.rdata;
	assign lane_char         = q.ch;
	assign lane_is_k         = q.k;
	assign lane_hold_low     = q.lo;
	assign lane_hold_high    = q.hi;
	assign ser_power_down    = q.pd;
	assign tx_clk_enable     = q.cke;
	assign bit_rate_quarters = q.rate;
endmodule : slk_dev

`default_nettype wire

// ### src/slk_host.sv
`timescale 1ns/1ps
`default_nettype none
`include "slk_regs.svh"

module slk_host (
	// clock and reset
	input  wire logic        clk,
	input  wire logic        rst,
	// software port
	input  wire logic [2:0]  addr,
	input  wire logic [15:0] wdata,
	input  wire logic        wr,
	input  wire logic        rd,
	output logic [15:0]      rdata,
	// register port to the transmitter
	slk_if.host              bus
);
	import slk_pkg::*;

	typedef struct packed {
		logic [9:0]  taddr;
		logic [7:0]  twd;
		logic [7:0]  sh;
		logic [7:0]  rbyte;
		logic        busy;
		logic        done;
		logic        rd_op;
		slk_hst_t    st;
		logic [15:0] rdata;
		logic [9:0]  ba;
		logic [7:0]  bw;
		logic        bwr;
		logic        brd;
	} slk_host_st_t;

	slk_host_st_t q, d;
	logic         go;
	logic         go_rd;
	logic         is_c1;
	logic         is_cfg;
	logic         need_pre;

	// a guarded write costs one extra bus cycle but keeps the link from seeing a live change
	always_comb begin
		d = q;
		go = wr && (addr == `SLK_HR_CMD) && (wdata[1:0] != 2'b00) && !q.busy;
		go_rd = wdata[1];
		is_c1 = (q.taddr == `SLK_OFS_CTRL1);
		is_cfg = (q.taddr == `SLK_OFS_CTRL2) || (q.taddr == `SLK_OFS_DID)
			|| (q.taddr == `SLK_OFS_CTRL3);
		need_pre = q.sh[`SLK_C1_EN] && (is_cfg
			|| (is_c1 && q.twd[7:1] != q.sh[7:1]));
		// software register writes and one-cycle reads
		if (wr && addr == `SLK_HR_ADDR)
			d.taddr = wdata[9:0];
		if (wr && addr == `SLK_HR_WDATA)
			d.twd = wdata[7:0];
		d.rdata = '0;
		if (rd) begin
			unique case (addr)
				`SLK_HR_ADDR:  d.rdata = {6'h00, q.taddr};
				`SLK_HR_WDATA: d.rdata = {8'h00, q.twd};
				`SLK_HR_STAT:  d.rdata = {q.rbyte, 5'h00, q.sh[`SLK_C1_EN], q.done, q.busy};
				default:       d.rdata = '0;
			endcase
		end
		// bus sequencer, strobes last one cycle
		d.bwr = 1'b0;
		d.brd = 1'b0;
		unique case (q.st)
			slk_h_idle: begin
				if (go) begin
					d.busy = 1'b1;
					d.done = 1'b0;
					d.rd_op = go_rd;
					if (!go_rd && need_pre) begin
						d.st = slk_h_pre;
						d.ba = `SLK_OFS_CTRL1;
						d.bw = q.sh;
						d.bw[`SLK_C1_EN] = 1'b0;
						d.bwr = 1'b1;
						d.sh[`SLK_C1_EN] = 1'b0;
					end else begin
						d.st = slk_h_acc;
						d.ba = q.taddr;
						d.bw = q.twd;
						d.bwr = !go_rd;
						d.brd = go_rd;
						if (!go_rd && is_c1)
							d.sh = q.twd;
					end
				end
			end
			slk_h_pre: begin
				d.st = slk_h_acc;
				d.ba = q.taddr;
				d.bw = q.twd;
				d.bwr = 1'b1;
				if (is_c1)
					d.sh = q.twd;
			end
			slk_h_acc: begin
				if (q.rd_op) begin
					d.st = slk_h_cap;
				end else begin
					d.st = slk_h_idle;
					d.busy = 1'b0;
					d.done = 1'b1;
				end
			end
			slk_h_cap: begin
				d.rbyte = bus.rdata;
				d.st = slk_h_idle;
				d.busy = 1'b0;
				d.done = 1'b1;
			end
		endcase
		if (rst) begin
			d = '0;
			d.sh = `SLK_RST_CTRL1;
			d.st = slk_h_idle;
		end
	end

	always_ff @(posedge clk) begin
		q <= d;
	end

	assign rdata     = q.rdata;
	assign bus.addr  = q.ba;
	assign bus.wdata = q.bw;
	assign bus.wr    = q.bwr;
	assign bus.rd    = q.brd;
endmodule : slk_host

`default_nettype wire

// ### verification/slk_sva.sv
`timescale 1ns/1ps
`default_nettype none

// watches the register port between the two ends and the lane outputs
module slk_sva (
	// clock and reset
	input wire logic       clk,
	input wire logic       rst,
	// register port
	input wire logic [9:0] addr,
	input wire logic [7:0] wdata,
	input wire logic       wr,
	input wire logic       rd,
	input wire logic [7:0] rdata,
	// lane and serializer
	input wire logic [7:0] lane_char,
	input wire logic       lane_is_k,
	input wire logic       lane_hold_low,
	input wire logic       lane_hold_high,
	input wire logic       ser_power_down,
	input wire logic       tx_clk_enable,
	input wire logic [3:0] bit_rate_quarters
);
	logic [7:0] ctrl1_q;

	default clocking cb @(posedge clk); endclocking
	default disable iff (rst);

	// shadow of the primary control as it crossed the port, to judge the guard
	always_ff @(posedge clk) begin
		ctrl1_q <= rst ? 8'h0f : ((wr && addr == 10'h201) ? wdata : ctrl1_q);
	end

	AST_PD_CKE: assert property (ser_power_down == !tx_clk_enable)
		else $error("power down and clock enable disagree");
	AST_OFF_PD: assert property (wr && addr == 10'h201 && !wdata[0] |-> ##[2:3] ser_power_down)
		else $error("serializers not powered down after disable");
	AST_OFF_CKE: assert property (wr && addr == 10'h201 && !wdata[0] |-> ##[2:3] !tx_clk_enable)
		else $error("transmitter clock still running after disable");
	AST_RATE: assert property (tx_clk_enable |-> bit_rate_quarters inside {4'h4, 4'h8, 4'h5, 4'ha})
		else $error("bit rate outside the legal set");
	AST_RATE_STABLE: assert property (tx_clk_enable && $past(tx_clk_enable) |-> $stable(bit_rate_quarters))
		else $error("bit rate moved while the link ran");
	AST_HOLD_LOW: assert property (lane_hold_low |-> lane_char == 8'h00 && !lane_is_k)
		else $error("held low lane not constant low");
	AST_HOLD_HIGH: assert property (lane_hold_high |-> lane_char == 8'hff && !lane_is_k)
		else $error("held high lane not constant high");
	AST_GUARD_PRI: assert property (wr && addr == 10'h201 && ctrl1_q[0] |-> wdata[7:1] == ctrl1_q[7:1])
		else $error("primary control changed while enabled");
	AST_GUARD_OTHER: assert property (wr && addr inside {10'h202, 10'h203, 10'h204} |-> !ctrl1_q[0])
		else $error("configuration written while enabled");
	AST_RESTART: assert property (wr && addr == 10'h201 && wdata[0] && !ctrl1_q[0]
		|-> ##[2:8] ((lane_char == 8'hbc && lane_is_k) || lane_hold_low || lane_hold_high))
		else $error("link did not restart from code group sync");

	// main scenarios reached
	COV_HOLD_HIGH: cover property (lane_hold_high);
	COV_FRAME_END: cover property (tx_clk_enable && lane_is_k && lane_char == 8'hfc);
	COV_ENABLE: cover property ($rose(tx_clk_enable));
endmodule : slk_sva

`default_nettype wire

// ### verification/tb_top.sv
`timescale 1ns/1ps
`default_nettype none

module tb_top;
	logic        clk;
	logic        rst;
	logic [2:0]  addr;
	logic [15:0] wdata;
	logic        wr;
	logic        rd;
	logic [15:0] rdata;
	logic        s_valid;
	logic [7:0]  s_data;
	logic        s_ready;
	logic        sync_se;
	logic        sync_diff;
	logic [7:0]  lane_char;
	logic        lane_is_k;
	logic        hold_lo;
	logic        hold_hi;
	logic        pd;
	logic        cke;
	logic [3:0]  rate;
	logic [15:0] v;
	int          n;
	int          errors;
	int          num_checks;
	logic [7:0]  rv [6] = '{8'h0f, 8'h00, 8'h00, 8'h00, 8'h60, 8'h00};
	logic [3:0]  rt [4] = '{4'h4, 4'h8, 4'h5, 4'ha};
	logic [7:0]  fe [3] = '{8'hfc, 8'h3c, 8'hbc};

	slk_if lnk ();
	slk_host slk_host_i (.clk(clk), .rst(rst), .addr(addr), .wdata(wdata), .wr(wr), .rd(rd),
		.rdata(rdata), .bus(lnk));
	slk_dev #(.FIFO_DEPTH(8)) slk_dev_i (.clk(clk), .rst(rst), .bus(lnk), .s_valid(s_valid),
		.s_data(s_data), .s_ready(s_ready), .sync_single_ended_input(sync_se),
		.sync_differential_input(sync_diff), .lane_char(lane_char), .lane_is_k(lane_is_k),
		.lane_hold_low(hold_lo), .lane_hold_high(hold_hi), .ser_power_down(pd),
		.tx_clk_enable(cke), .bit_rate_quarters(rate));
	slk_sva slk_sva_i (.clk(clk), .rst(rst), .addr(lnk.addr), .wdata(lnk.wdata), .wr(lnk.wr),
		.rd(lnk.rd), .rdata(lnk.rdata), .lane_char(lane_char), .lane_is_k(lane_is_k),
		.lane_hold_low(hold_lo), .lane_hold_high(hold_hi), .ser_power_down(pd),
		.tx_clk_enable(cke), .bit_rate_quarters(rate));

	task automatic check(input string what, input logic [15:0] exp, input logic [15:0] got);
		num_checks++;
		if (got !== exp) begin
			errors++;
			$display("FAIL %s expected %h seen %h", what, exp, got);
		end
	endtask : check

	// one software write, strobe high for a single edge
	task automatic sw_wr(input logic [2:0] a, input logic [15:0] d);
		@(posedge clk);
		addr  <= a;
		wdata <= d;
		wr    <= 1'b1;
		@(posedge clk);
		wr <= 1'b0;
	endtask : sw_wr

	// one software read, answer taken in the cycle after the strobe
	task automatic sw_rd(input logic [2:0] a, output logic [15:0] d);
		@(posedge clk);
		addr <= a;
		rd   <= 1'b1;
		@(posedge clk);
		rd <= 1'b0;
		#1 d = rdata;
	endtask : sw_rd

	// transmitter access through the controller; polls busy with a bound
	task automatic xfer(input logic [9:0] a, input logic [7:0] d, input logic [1:0] cmd);
		int k;
		k = 0;
		sw_wr(3'h0, {6'h00, a});
		sw_wr(3'h1, {8'h00, d});
		sw_wr(3'h2, {14'h0000, cmd});
		do begin
			sw_rd(3'h3, v);
			k++;
		end while (v[0] !== 1'b0 && k < 40);
		check("controller done", 16'h0002, {14'h0000, v[1:0]});
	endtask : xfer

	// run a few cycles, then sample settled outputs
	task automatic wait_clk(input int c);
		repeat (c) @(posedge clk);
		#1;
	endtask : wait_clk

	task automatic print_verdict();
		$display("checks %0d errors %0d", num_checks, errors);
		if (errors == 0 && num_checks > 0) begin
			$display("ALL CHECKS OK");
		end else begin
			$display("CHECKS NOT OK");
		end
		$finish;
	endtask : print_verdict

	// clock at 250 MHz
	initial begin
		clk = 1'b0;
		forever #2 clk = ~clk;
	end

	// a hang counts as a mismatch
	initial begin
		#100000;
		errors++;
		print_verdict();
	end

	// main sequence
	initial begin
		{addr, wdata, wr, rd, s_valid, s_data, errors, num_checks} = '0;
		rst = 1'b1;
		{sync_se, sync_diff} = 2'b11;
		repeat (20) @(posedge clk);
		rst <= 1'b0;
		for (int i = 0; i < 6; i++) begin
			xfer(10'(i) + 10'h201, 8'h00, 2'b10);
			check("reset value", {8'h00, rv[i]}, {8'h00, v[15:8]});
		end
		// every rate combination, guard drops enable before ctrl2 changes
		// active copy and outputs settle two edges after the controller reports done
		for (int i = 0; i < 4; i++) begin
			xfer(10'h202, {i[1], 7'h00}, 2'b01);
			xfer(10'h201, i[0] ? 8'h0f : 8'h0d, 2'b01);
			wait_clk(2);
			check("bit rate", {12'h000, rt[i]}, {12'h000, rate});
		end
		xfer(10'h201, 8'h0e, 2'b01);
		wait_clk(2);
		check("power down", 16'h0001, {15'h0000, pd});
		check("clock enable", 16'h0000, {15'h0000, cke});
		xfer(10'h205, 8'h00, 2'b10);
		check("link up off", 16'h0000, {15'h0000, v[14]});
		// test codes 1 to 11; fixed patterns checked by value
		for (int c = 1; c < 12; c++) begin
			xfer(10'h202, 8'(c), 2'b01);
			xfer(10'h201, 8'h0f, 2'b01);
			wait_clk(30);
			check("hold flags", {14'h0, c == 11, c == 10}, {14'h0, hold_hi, hold_lo});
			if (c inside {6, 7, 10, 11}) begin
				check("test char", c == 6 ? 16'h00b5 : c == 7 ? 16'h01bc : c == 10 ? 16'h0 : 16'h00ff,
					{7'h0, lane_is_k, lane_char});
			end
		end
		// identifier in the second multiframe; sync held asserted to catch the start
		@(posedge clk) sync_se <= 1'b0;
		xfer(10'h203, 8'ha5, 2'b01);
		xfer(10'h202, 8'h00, 2'b01);
		xfer(10'h201, 8'h0f, 2'b01);
		wait_clk(4);
		check("code group", 16'h01bc, {7'h0, lane_is_k, lane_char});
		@(posedge clk) sync_se <= 1'b1;
		n = 0;
		do begin
			wait_clk(1);
			n++;
		end while (!(lane_char === 8'h1c && lane_is_k === 1'b1) && n < 20);
		wait_clk(6);
		check("identifier", 16'h00a5, {7'h0, lane_is_k, lane_char});
		// let the rest of the alignment sequence finish before asking for link up
		wait_clk(12);
		xfer(10'h205, 8'h00, 2'b10);
		check("status up", 16'h0060, {8'h00, v[15:8]});
		// unselected sync pin is ignored, selected one stops the link
		@(posedge clk) sync_diff <= 1'b0;
		xfer(10'h205, 8'h00, 2'b10);
		check("status single", 16'h0060, {8'h00, v[15:8]});
		xfer(10'h202, 8'h40, 2'b01);
		xfer(10'h201, 8'h0f, 2'b01);
		xfer(10'h205, 8'h00, 2'b10);
		check("status diff low", 16'h0000, {8'h00, v[15:8]});
		@(posedge clk) begin
			sync_diff <= 1'b1;
			sync_se   <= 1'b0;
		end
		// synchroniser, code group sync and four multiframes before data
		wait_clk(24);
		xfer(10'h205, 8'h00, 2'b10);
		check("status diff high", 16'h0060, {8'h00, v[15:8]});
		@(posedge clk) sync_se <= 1'b1;
		// repeated bytes fill the buffer while off, then show the frame end char
		for (int c = 0; c < 3; c++) begin
			xfer(10'h204, 8'(c), 2'b01);
			@(posedge clk) begin
				s_valid <= 1'b1;
				s_data  <= 8'h55;
			end
			wait_clk(12);
			check("fifo full", 16'h0000, {15'h0000, s_ready});
			xfer(10'h201, 8'h0f, 2'b01);
			wait_clk(24);
			n = 0;
			while (!(lane_is_k === 1'b1 && lane_char === fe[c]) && n < 64) begin
				wait_clk(1);
				n++;
			end
			check("frame end", {8'h01, fe[c]}, {7'h0, lane_is_k, lane_char});
			@(posedge clk) s_valid <= 1'b0;
		end
		// scrambled repeats go out as data: 55 then 56 from the all-ones seed
		xfer(10'h201, 8'h0e, 2'b01);
		@(posedge clk) s_valid <= 1'b1;
		xfer(10'h201, 8'h8f, 2'b01);
		n = 0;
		do begin
			wait_clk(1);
			n++;
		end while (!(lane_char === 8'h1c && lane_is_k === 1'b1) && n < 20);
		wait_clk(16);
		check("scrambled first", 16'h0055, {7'h0, lane_is_k, lane_char});
		wait_clk(1);
		check("scrambled second", 16'h0056, {7'h0, lane_is_k, lane_char});
		@(posedge clk) s_valid <= 1'b0;
		print_verdict();
	end
endmodule : tb_top

`default_nettype wire
